//--- verilog/drive_input_stop_trip_guard.sv
// Coast-stop, external trip and power-on start guard for a motor drive.
// Assumes terminal inputs already synchronous to clk; sys_rst is power-up.
//
// Contract
// - Coast-stop input removes motor drive at once
// - Coast release resumes only if run active
// - Restart from zero or matched speed
// - Restart delay after coast; zero disables
// - Per-terminal polarity allows active-low coast
// - Fault rising edge latches external trip
// - Fault falling edge never trips; history kept
// - External trip persists until reset
// - Trip coasts motor and raises alarm immediately
// - Reset clears alarm; run resumes without guard
// - Guarded external clear by keypad needs fresh intervention
// - No guard: run active at power-up starts
// - Guard: run at power-up gives guard trip
// - Run off or reset clears guard trip
// - Reset input clears guard trip, runs immediately
// - Undervoltage clear still applies start guard
// - Reset acts on fault-clear on-then-off
// - Power-up performs same reset operation
// - Either run input runs; both stop
`timescale 1ns/100ps
`default_nettype none
`include "guard_defs.svh"

module drive_input_stop_trip_guard #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [7:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic [6:0]   terminal_in,
    input  wire logic         undervoltage_fault,
    output logic              motor_enable,
    output logic              alarm_out,
    output logic              restart_from_match,
    output logic [7:0]        error_code,
    output guard_pkg::trip_t  trip_reason
);
    import guard_pkg::*;

    // Any function on any terminal; several terminals may share one code
    function automatic logic func_active(input logic [55:0] codes,
                                         input logic [6:0]  lvl,
                                         input logic [7:0]  code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (codes[i*8 +: 8] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] err_of(input trip_t t);
        case (t)
            TRIP_EXT: return `ERR_EXT;
            TRIP_USP: return `ERR_USP;
            TRIP_UV:  return `ERR_UV;
            default:  return `ERR_NONE;
        endcase
    endfunction

    // Register bus state
    logic        ack;
    logic [31:0] rdata;
    logic        match_sel;
    logic [15:0] delay_ms;
    logic [6:0]  polarity;
    logic [55:0] func;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic        next_match_sel;
    logic [15:0] next_delay_ms;
    logic [6:0]  next_polarity;
    logic [55:0] next_func;
    logic        wr_now;
    logic        keypad_reset;
    logic [31:0] lo_word;
    logic [31:0] hi_word;

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_now          = avs_write && ack;
    assign keypad_reset    = wr_now && (avs_address == `REG_KEYPAD)
                             && avs_byteenable[0] && avs_writedata[`KEYPAD_RST_BIT];
    assign avs_readdata    = rdata;
    assign lo_word         = func[31:0];
    assign hi_word         = {8'h00, func[55:32]};

    always_comb begin
        next_ack       = (avs_read || avs_write) && !ack;
        next_rdata     = rdata;
        next_match_sel = match_sel;
        next_delay_ms  = delay_ms;
        next_polarity  = polarity;
        next_func      = func;
        if (avs_read && !ack) begin
            case (avs_address)
                `REG_CTRL:     next_rdata = {31'h0000_0000, match_sel};
                `REG_DELAY:    next_rdata = {16'h0000, delay_ms};
                `REG_POLARITY: next_rdata = {25'h000_0000, polarity};
                `REG_FUNC_LO:  next_rdata = lo_word;
                `REG_FUNC_HI:  next_rdata = hi_word;
                `REG_STATUS:   next_rdata = {16'h0000, error_code, 5'h00,
                                             restart_from_match, alarm_out, motor_enable};
                default:       next_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_now) begin
            case (avs_address)
                `REG_CTRL:     next_match_sel = avs_byteenable[0] ?
                                   avs_writedata[`CTRL_MATCH_BIT] : match_sel;
                `REG_DELAY:    next_delay_ms = 16'(merge_be({16'h0000, delay_ms},
                                   avs_writedata, avs_byteenable));
                `REG_POLARITY: next_polarity = 7'(merge_be({25'h000_0000, polarity},
                                   avs_writedata, avs_byteenable));
                `REG_FUNC_LO:  next_func[31:0] = merge_be(lo_word, avs_writedata,
                                   avs_byteenable);
                `REG_FUNC_HI:  next_func[55:32] = 24'(merge_be(hi_word, avs_writedata,
                                   avs_byteenable));
                default:       next_func = func;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack       <= 1'b0;
            rdata     <= 32'h0000_0000;
            match_sel <= `CTRL_RST;
            delay_ms  <= `DELAY_RST;
            polarity  <= `POLARITY_RST;
            func      <= `FUNC_RST;
        end else begin
            ack       <= next_ack;
            rdata     <= next_rdata;
            match_sel <= next_match_sel;
            delay_ms  <= next_delay_ms;
            polarity  <= next_polarity;
            func      <= next_func;
        end
    end

    // Input function decode
    logic [6:0] lvl;
    logic       fwd_on;
    logic       rev_on;
    logic       run_cmd;
    logic       coast_on;
    logic       ext_now;
    logic       usp_on;
    logic       rs_now;

    assign lvl      = terminal_in ^ polarity;
    assign fwd_on   = func_active(func, lvl, `FC_FWD);
    assign rev_on   = func_active(func, lvl, `FC_REV);
    assign run_cmd  = fwd_on ^ rev_on;
    assign coast_on = func_active(func, lvl, `FC_COAST);
    assign ext_now  = func_active(func, lvl, `FC_EXT);
    assign usp_on   = func_active(func, lvl, `FC_USP);
    // Fault-clear is normally open only, so polarity is ignored for it
    assign rs_now   = func_active(func, terminal_in, `FC_RESET);

    // Control state
    drive_state_t state;
    trip_t        trip;
    logic         pending;
    logic         lock;
    logic         coasted;
    logic         ext_prev;
    logic         rs_prev;
    logic         match;
    drive_state_t next_state;
    trip_t        next_trip;
    logic         next_pending;
    logic         next_lock;
    logic         next_coasted;
    logic         next_match;
    logic         timer_start;
    logic         timer_done;
    logic         ext_rise;
    logic         rs_fall;

    assign ext_rise = ext_now && !ext_prev;
    assign rs_fall  = rs_prev && !rs_now;

    always_comb begin
        next_state   = state;
        next_trip    = trip;
        next_pending = pending;
        next_lock    = lock;
        next_coasted = coasted;
        next_match   = match;
        timer_start  = 1'b0;
        if (rs_now) begin
            next_state = ST_STOP;
        end else if (rs_fall) begin
            // Reset operation; guard trip cleared here restarts at once
            next_trip    = TRIP_NONE;
            next_lock    = 1'b0;
            next_coasted = 1'b0;
            next_pending = (trip == TRIP_UV) || (trip == TRIP_NONE);
            next_state   = ST_STOP;
            // A fault edge in the clearing cycle must not be lost: set wins
            if (ext_rise) begin
                next_trip    = TRIP_EXT;
                next_pending = 1'b0;
            end
        end else if ((ext_rise || undervoltage_fault) && trip == TRIP_NONE) begin
            next_trip    = ext_rise ? TRIP_EXT : TRIP_UV;
            next_state   = ST_STOP;
            next_coasted = 1'b0;
            next_pending = 1'b0;
        end else if (trip != TRIP_NONE) begin
            next_state = ST_STOP;
            if (keypad_reset) begin
                next_trip = TRIP_NONE;
                next_lock = usp_on && run_cmd;
            end else if (trip == TRIP_USP && !run_cmd) begin
                next_trip = TRIP_NONE;
            end
        end else if (pending) begin
            next_pending = 1'b0;
            if (usp_on && run_cmd) begin
                next_trip = TRIP_USP;
            end
        end else begin
            case (state)
                ST_STOP: begin
                    if (!run_cmd) begin
                        next_lock    = 1'b0;
                        next_coasted = 1'b0;
                    end
                    if (run_cmd && !coast_on && !lock) begin
                        if (coasted) begin
                            next_state  = ST_DELAY;
                            timer_start = 1'b1;
                        end else begin
                            next_state = ST_RUN;
                            next_match = 1'b0;
                        end
                    end
                end
                ST_DELAY: begin
                    if (!run_cmd || coast_on) begin
                        next_state = ST_STOP;
                    end else if (timer_done) begin
                        next_state   = ST_RUN;
                        next_match   = match_sel;
                        next_coasted = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (coast_on) begin
                        next_state   = ST_STOP;
                        next_coasted = 1'b1;
                    end else if (!run_cmd) begin
                        next_state = ST_STOP;
                    end
                end
                default: next_state = ST_STOP;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ST_STOP;
            trip     <= TRIP_NONE;
            pending  <= 1'b1;
            lock     <= 1'b0;
            coasted  <= 1'b0;
            ext_prev <= 1'b0;
            rs_prev  <= 1'b0;
            match    <= 1'b0;
        end else begin
            state    <= next_state;
            trip     <= next_trip;
            pending  <= next_pending;
            lock     <= next_lock;
            coasted  <= next_coasted;
            ext_prev <= ext_now;
            rs_prev  <= rs_now;
            match    <= next_match;
        end
    end

    restart_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_delay (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (timer_start),
        .delay_ms (delay_ms),
        .done     (timer_done)
    );

    assign motor_enable       = (state == ST_RUN);
    assign alarm_out          = (trip != TRIP_NONE);
    assign restart_from_match = match;
    assign error_code         = err_of(trip);
    assign trip_reason        = trip;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_enter_delay;
        (state == ST_STOP) ##1 (state == ST_DELAY);
    endsequence

    sequence seq_quiet;
        !rs_now && !rs_fall && !keypad_reset;
    endsequence

    a_coast_cuts_drive: assert property (
        (motor_enable && coast_on && !rs_now) |=> !motor_enable)
        else $error("coast-stop did not remove drive");
    a_ext_latches: assert property (
        (ext_rise && !rs_now && !rs_fall && trip == TRIP_NONE)
        |=> (trip == TRIP_EXT) && alarm_out && error_code == `ERR_EXT)
        else $error("external fault edge did not trip");
    a_ext_fall_quiet: assert property (
        (ext_prev && !ext_now && trip == TRIP_NONE) |=> trip != TRIP_EXT)
        else $error("fault release created a trip");
    a_trip_holds: assert property (
        ((trip == TRIP_EXT) and seq_quiet) |=> trip == TRIP_EXT)
        else $error("external trip cleared without reset");
    a_trip_no_drive: assert property (
        (trip != TRIP_NONE) |-> (!motor_enable && alarm_out) ##1 !motor_enable)
        else $error("drive active while tripped");
    a_rs_clears: assert property (
        rs_fall |=> (trip == ($past(ext_rise) ? TRIP_EXT : TRIP_NONE))
                    && (alarm_out == $past(ext_rise)))
        else $error("fault-clear release left trip set");
    a_guard_trips: assert property (
        ((pending && usp_on && run_cmd && trip == TRIP_NONE
          && !ext_rise && !undervoltage_fault) and seq_quiet)
        |=> trip == TRIP_USP ##1 !motor_enable)
        else $error("run at power-up not caught by start guard");
    a_both_stop: assert property (
        (state == ST_RUN && fwd_on && rev_on && !rs_now) |=> !motor_enable)
        else $error("both run inputs did not stop drive");
    a_zero_delay: assert property (
        (seq_enter_delay ##0 ((delay_ms == 16'h0000 && run_cmd && !coast_on
         && trip == TRIP_NONE && !ext_rise && !undervoltage_fault) and seq_quiet))
        |=> motor_enable)
        else $error("zero restart delay still waited");
endmodule
`default_nettype wire

//--- include/guard_defs.svh
// Constants for the coast-stop, external-trip and start-guard block.
// Included by the package and by the design modules; definitions only.
`ifndef GUARD_DEFS_SVH
`define GUARD_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define REG_CTRL      8'h00
`define REG_DELAY     8'h04
`define REG_POLARITY  8'h08
`define REG_FUNC_LO   8'h0C
`define REG_FUNC_HI   8'h10
`define REG_STATUS    8'h14
`define REG_KEYPAD    8'h18

// Field positions
`define CTRL_MATCH_BIT   0
`define KEYPAD_RST_BIT   0
`define ST_ENABLE_BIT    0
`define ST_ALARM_BIT     1
`define ST_MATCH_BIT     2
`define ST_ERR_LSB       8

// Terminal function codes (one byte per terminal)
`define FC_FWD    8'h00
`define FC_REV    8'h01
`define FC_COAST  8'h0B
`define FC_USP    8'h0D
`define FC_EXT    8'h0F
`define FC_RESET  8'h12
`define FC_NONE   8'hFF

// Error codes shown while tripped
`define ERR_NONE  8'h00
`define ERR_UV    8'h09
`define ERR_EXT   8'h0C
`define ERR_USP   8'h0D

// Reset values
`define FUNC_RST      56'hFF_120D_0F0B_0100
`define POLARITY_RST  7'h00
`define DELAY_RST     16'h0000
`define CTRL_RST      1'b0

// Restart delay unit: one millisecond tick
`define CLK_MHZ          100
`define TICK_PERIOD_US   1000
`define TICK_CYCLES      (`TICK_PERIOD_US * `CLK_MHZ)

`endif

//--- include/guard_pkg.sv
// Types shared by the stop/trip guard modules.
// Assumes guard_defs.svh is on the include path.
`include "guard_defs.svh"

package guard_pkg;
    typedef enum logic [1:0] {
        ST_STOP,
        ST_DELAY,
        ST_RUN
    } drive_state_t;

    typedef enum logic [1:0] {
        TRIP_NONE,
        TRIP_EXT,
        TRIP_USP,
        TRIP_UV
    } trip_t;
endpackage

//--- verilog/restart_timer.sv
// Restart delay timer counting whole milliseconds.
// Assumes a one-cycle start pulse; done holds until the next start.
`timescale 1ns/100ps
`default_nettype none
`include "guard_defs.svh"

module restart_timer #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [15:0] delay_ms,
    output logic             done
);
    logic        busy;
    logic [15:0] remaining;
    logic [16:0] prescale;
    logic        next_busy;
    logic [15:0] next_remaining;
    logic [16:0] next_prescale;

    always_comb begin
        next_busy      = busy;
        next_remaining = remaining;
        next_prescale  = prescale;
        if (start) begin
            next_busy      = 1'b1;
            next_remaining = delay_ms;
            next_prescale  = 17'h0_0000;
        end else if (busy && remaining != 16'h0000) begin
            if (prescale == 17'(TICK_CYCLES - 1)) begin
                next_prescale  = 17'h0_0000;
                next_remaining = remaining - 16'h0001;
            end else begin
                next_prescale = prescale + 17'h0_0001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy      <= 1'b0;
            remaining <= 16'h0000;
            prescale  <= 17'h0_0000;
        end else begin
            busy      <= next_busy;
            remaining <= next_remaining;
            prescale  <= next_prescale;
        end
    end

    // Zero delay expires at once, so no waiting
    assign done = busy && (remaining == 16'h0000);
endmodule
`default_nettype wire

//--- dv/terminal_switches.sv
// Switch-panel model that drives the seven input terminals.
// Assumes the default function map; coast may move to another pin.
`timescale 1ns/100ps
`default_nettype none

module terminal_switches (
    input  wire logic       fwd,
    input  wire logic       rev,
    input  wire logic       coast,
    input  wire logic       ext_fault,
    input  wire logic       guard,
    input  wire logic       clear,
    input  wire logic [6:0] active_low,
    input  wire logic [2:0] coast_pin,
    output logic [6:0]      terminal_in
);
    logic [6:0] level;

    always_comb begin
        level = {1'b0, clear, guard, ext_fault, 1'b0, rev, fwd};
        level[coast_pin] = level[coast_pin] | coast;
        // Normally closed contact opens when its function is on
        terminal_in = level ^ active_low;
    end
endmodule

`default_nettype wire

//--- dv/test_drive_input_stop_trip_guard.sv
// Self-checking bench for the coast-stop, trip and start-guard block.
// Assumes the switch model beside it and a shortened delay tick.
`timescale 1ns/100ps
`default_nettype none
`include "guard_defs.svh"

module test_drive_input_stop_trip_guard;
    import guard_pkg::*;
    localparam int TICK = 4;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wreq;
    logic [6:0]  term;
    logic        uv;
    logic        motor;
    logic        alarm;
    logic        match;
    logic [7:0]  err;
    trip_t       reason;
    logic        fwd;
    logic        rev;
    logic        coast;
    logic        external_fault_input;
    logic        grd;
    logic        clr;
    logic [6:0]  pol;
    logic [2:0]  cpin;
    logic [31:0] q;
    int          num_errors;
    int          n_compared;
    int          n;

    drive_input_stop_trip_guard #(.TICK_CYCLES(TICK)) uut (
        .clk(clk), .sys_rst(sys_rst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .terminal_in(term),
        .undervoltage_fault(uv), .motor_enable(motor), .alarm_out(alarm),
        .restart_from_match(match), .error_code(err), .trip_reason(reason));

    terminal_switches panel (
        .fwd(fwd), .rev(rev), .coast(coast), .ext_fault(external_fault_input), .guard(grd),
        .clear(clr), .active_low(pol), .coast_pin(cpin), .terminal_in(term));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic outs(input logic m, input logic a, input logic [7:0] e);
        chk("motor_enable", 32'(m), 32'(motor));
        chk("alarm_out", 32'(a), 32'(alarm));
        chk("error_code", 32'(e), 32'(err));
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wait_motor(input logic e, input int lim);
        n = 0;
        while (motor !== e && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("motor_enable", 32'(e), 32'(motor));
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        // Sampled at the rising edge, before the slave's own update lands
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        q = rdata;
        if (k >= 20) begin
            num_errors++;
            end_sim();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask

    task automatic power_up;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic pulse_clear;
        @(posedge clk);
        clr <= 1'b1;
        cyc(2);
        @(posedge clk);
        clr <= 1'b0;
    endtask

    task automatic t_regs;
        rd_chk("ctrl", `REG_CTRL, 32'h0000_0000);
        rd_chk("delay", `REG_DELAY, 32'h0000_0000);
        rd_chk("polarity", `REG_POLARITY, 32'h0000_0000);
        rd_chk("func_lo", `REG_FUNC_LO, 32'h0F0B_0100);
        rd_chk("func_hi", `REG_FUNC_HI, 32'h00FF_120D);
        rd_chk("unmapped", 8'h1C, 32'h0000_0000);
        bus(1'b1, `REG_STATUS, 32'hFFFF_FFFF);
        rd_chk("status", `REG_STATUS, 32'h0000_0000);
        bus(1'b1, `REG_DELAY, 32'h0000_1234);
        rd_chk("delay", `REG_DELAY, 32'h0000_1234);
        $display("test registers done");
    endtask

    task automatic t_usp;
        @(posedge clk);
        grd <= 1'b1;
        fwd <= 1'b1;
        power_up;
        cyc(3);
        outs(1'b0, 1'b1, `ERR_USP);
        @(posedge clk);
        fwd <= 1'b0;
        cyc(3);
        outs(1'b0, 1'b0, `ERR_NONE);
        @(posedge clk);
        fwd <= 1'b1;
        wait_motor(1'b1, 4);
        @(posedge clk);
        uv <= 1'b1;
        cyc(2);
        outs(1'b0, 1'b1, `ERR_UV);
        @(posedge clk);
        uv <= 1'b0;
        pulse_clear;
        cyc(3);
        outs(1'b0, 1'b1, `ERR_USP);
        pulse_clear;
        wait_motor(1'b1, 4);
        $display("test start guard done");
    endtask

    task automatic t_coast;
        bus(1'b1, `REG_DELAY, 32'h0000_0003);
        bus(1'b1, `REG_CTRL, 32'h0000_0001);
        @(posedge clk);
        coast <= 1'b1;
        cyc(1);
        outs(1'b0, 1'b0, `ERR_NONE);
        @(posedge clk);
        coast <= 1'b0;
        wait_motor(1'b1, 3 * TICK + 8);
        chk("restart_wait", 32'h1, 32'(n >= 3 * TICK));
        cyc(1);
        chk("restart_from_match", 32'h1, 32'(match));
        bus(1'b1, `REG_DELAY, 32'h0000_0000);
        bus(1'b1, `REG_CTRL, 32'h0000_0000);
        @(posedge clk);
        coast <= 1'b1;
        cyc(2);
        @(posedge clk);
        coast <= 1'b0;
        wait_motor(1'b1, 4);
        cyc(1);
        chk("restart_from_match", 32'h0, 32'(match));
        @(posedge clk);
        coast <= 1'b1;
        fwd <= 1'b0;
        cyc(2);
        @(posedge clk);
        coast <= 1'b0;
        cyc(3 * TICK + 8);
        outs(1'b0, 1'b0, `ERR_NONE);
        bus(1'b1, `REG_POLARITY, 32'h0000_0004);
        @(posedge clk);
        pol <= 7'h04;
        fwd <= 1'b1;
        wait_motor(1'b1, 8);
        @(posedge clk);
        coast <= 1'b1;
        cyc(1);
        outs(1'b0, 1'b0, `ERR_NONE);
        bus(1'b1, `REG_POLARITY, 32'h0000_0000);
        @(posedge clk);
        pol <= 7'h00;
        coast <= 1'b0;
        wait_motor(1'b1, 8);
        $display("test coast done");
    endtask

    task automatic t_ext;
        @(posedge clk);
        grd <= 1'b0;
        external_fault_input <= 1'b1;
        cyc(1);
        outs(1'b0, 1'b1, `ERR_EXT);
        chk("trip_reason", 32'(TRIP_EXT), 32'(reason));
        @(posedge clk);
        external_fault_input <= 1'b0;
        coast <= 1'b1;
        cyc(3);
        @(posedge clk);
        coast <= 1'b0;
        external_fault_input <= 1'b1;
        cyc(3);
        outs(1'b0, 1'b1, `ERR_EXT);
        pulse_clear;
        wait_motor(1'b1, 4);
        outs(1'b1, 1'b0, `ERR_NONE);
        @(posedge clk);
        external_fault_input <= 1'b0;
        cyc(3);
        outs(1'b1, 1'b0, `ERR_NONE);
        @(posedge clk);
        grd <= 1'b1;
        external_fault_input <= 1'b1;
        cyc(1);
        @(posedge clk);
        external_fault_input <= 1'b0;
        bus(1'b1, `REG_KEYPAD, 32'h0000_0001);
        cyc(4);
        outs(1'b0, 1'b0, `ERR_NONE);
        @(posedge clk);
        fwd <= 1'b0;
        cyc(2);
        @(posedge clk);
        fwd <= 1'b1;
        wait_motor(1'b1, 4);
        $display("test external trip done");
    endtask

    task automatic t_dir;
        @(posedge clk);
        rev <= 1'b1;
        cyc(2);
        chk("motor_enable", 32'h0, 32'(motor));
        @(posedge clk);
        fwd <= 1'b0;
        wait_motor(1'b1, 4);
        bus(1'b1, `REG_FUNC_LO, 32'h0FFF_0100);
        bus(1'b1, `REG_FUNC_HI, 32'h000B_120D);
        @(posedge clk);
        cpin <= 3'd6;
        coast <= 1'b1;
        cyc(2);
        chk("motor_enable", 32'h0, 32'(motor));
        @(posedge clk);
        grd <= 1'b0;
        fwd <= 1'b1;
        rev <= 1'b0;
        coast <= 1'b0;
        power_up;
        wait_motor(1'b1, 4);
        $display("test direction and power-up done");
    endtask

    initial begin
        sys_rst = 1'b1;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0000_0000;
        uv = 1'b0;
        {fwd, rev, coast, external_fault_input, grd, clr} = 6'h00;
        pol = 7'h00;
        cpin = 3'd2;
        num_errors = 0;
        n_compared = 0;
        // Run stays off across power-up
        power_up;
        t_regs;
        t_usp;
        t_coast;
        t_ext;
        t_dir;
        end_sim;
    end
endmodule

`default_nettype wire
